// File: hw/lhs_regs.vh
// Constants for the frame header engine: field codes, timing and states.
// Assumes inclusion by bare name from the design files under hw/.
`ifndef LHS_REGS_VH
`define LHS_REGS_VH
// ----------------------------------------------------------------------------
// Fixed field values
// ----------------------------------------------------------------------------
`define LHS_SYNC_BYTE       8'h55
`define LHS_BREAK_BITS      5'h0D
`define LHS_CHAR_BITS       4'hA
// ----------------------------------------------------------------------------
// Default bit time: 19200 baud at 100 MHz, bit time in ns and in cycles
// ----------------------------------------------------------------------------
`define LHS_BIT_TIME_NS     52083
`define LHS_CLK_PERIOD_NS   10
`define LHS_BIT_CYCLES      ((`LHS_BIT_TIME_NS) / (`LHS_CLK_PERIOD_NS))
// ----------------------------------------------------------------------------
// Slave receive states
// ----------------------------------------------------------------------------
`define LHS_RX_IDLE         3'h0
`define LHS_RX_BREAK        3'h1
`define LHS_RX_WAITSYNC     3'h2
`define LHS_RX_MEASURE      3'h3
`define LHS_RX_ID           3'h4
// ----------------------------------------------------------------------------
// Master transmit states
// ----------------------------------------------------------------------------
`define LHS_TX_IDLE         2'h0
`define LHS_TX_BREAK        2'h1
`define LHS_TX_DELIM        2'h2
`define LHS_TX_CHAR         2'h3
`endif

// File: hw/lhs_fifo.v
// Synchronous FIFO with valid/ready on both sides, flip-flop storage.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/10ps
`default_nettype none
module lhs_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 8,
	parameter AW    = 3
) (
	// Clock and reset
	input  wire             clk_i,
	input  wire             nrst_i,
	// Fill side
	input  wire             in_valid_i,
	output wire             in_ready_o,
	input  wire [WIDTH-1:0] in_data_i,
	// Drain side
	output wire             out_valid_o,
	input  wire             out_ready_i,
	output wire [WIDTH-1:0] out_data_o
);
	reg  [WIDTH-1:0] mem_q [0:DEPTH-1];
	reg  [AW-1:0]    wr_q;
	reg  [AW-1:0]    rd_q;
	reg  [AW:0]      cnt_q;
	wire             push;
	wire             pop;

	assign in_ready_o  = (cnt_q != DEPTH[AW:0]);
	assign out_valid_o = (cnt_q != {(AW+1){1'b0}});
	assign out_data_o  = mem_q[rd_q];
	assign push        = in_valid_i & in_ready_o;
	assign pop         = out_valid_o & out_ready_i;

	always @(posedge clk_i) begin
		if (push) begin
			mem_q[wr_q] <= in_data_i;
		end
	end

	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			wr_q  <= {AW{1'b0}};
			rd_q  <= {AW{1'b0}};
			cnt_q <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
			end
			if (push && !pop) begin
				cnt_q <= cnt_q + 1'b1;
			end else if (pop && !push) begin
				cnt_q <= cnt_q - 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// File: hw/lhs_core.v
// Frame header engine: master header sender and slave header detector with
// per-frame baud measurement. Received identifier bytes leave via a FIFO.
// Assumes rx_i is already synchronous to clk_i; low on the line is dominant.
// The measured bit time also sets the break threshold for the next header.
//
// How it works
// - A header is only started while master_i is high; in slave mode no header starts.
// - The header goes out as break, then sync byte, then identifier, never another order.
// - The break is a timed low level; sync and identifier are normal 8N1 characters.
// - The break holds the line dominant for 13 bit times.
// - A slave sees a break followed by a sync byte as a new frame and is aligned for the identifier.
// - After enable the slave arms reception and its timer, waits for a header, then adopts the rate.
// - The bit time is remeasured on every header; the previous value only sets that header's break threshold.
// - The sync field carries 55h, whose falling edges span eight bit times.
// - A dedicated measuring timer counts the sync field to give the bit time.
`timescale 1ns/10ps
`default_nettype none
`include "lhs_regs.vh"
module lhs_core #(
	parameter CW        = 20,
	parameter BIT_CYC   = `LHS_BIT_CYCLES,
	parameter FIFO_DEPTH = 8
) (
	// Clock and reset
	input  wire       clk_i,
	input  wire       nrst_i,
	// Mode and header request
	input  wire       enable_i,
	input  wire       master_i,
	input  wire       send_i,
	input  wire [7:0] send_id_i,
	// Bus line
	input  wire       rx_i,
	output reg        tx_o,
	// Status
	output reg        busy_o,
	output reg        synced_o,
	output reg [CW-1:0] bit_cycles_o,
	output reg        frame_o,
	// Received identifier stream
	output reg        id_valid_o,
	input  wire       id_ready_i,
	output reg  [7:0] id_data_o
);
	// ------------------------------------------------------------------------
	// Master transmit
	// ------------------------------------------------------------------------
	reg  [1:0]    tx_st_q;
	reg  [CW-1:0] tx_cnt_q;
	reg  [4:0]    tx_bit_q;
	reg  [9:0]    tx_sh_q;
	reg           tx_second_q;
	reg  [7:0]    tx_id_q;
	wire [CW-1:0] bit_last;
	wire          tx_tick;

	// One bit time is BIT_CYC clocks; the divider pulses tx_tick on its last count.
	assign bit_last = BIT_CYC[CW-1:0] - 1'b1;
	assign tx_tick  = (tx_cnt_q == bit_last);

	// Transmitter: break as a timed low level, then two framed characters.
	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			tx_st_q     <= `LHS_TX_IDLE;
			tx_cnt_q    <= {CW{1'b0}};
			tx_bit_q    <= 5'h00;
			tx_sh_q     <= 10'h3FF;
			tx_second_q <= 1'b0;
			tx_id_q     <= 8'h00;
			tx_o        <= 1'b1;
			busy_o      <= 1'b0;
		end else begin
			tx_cnt_q <= (tx_st_q == `LHS_TX_IDLE || tx_tick) ? {CW{1'b0}} : tx_cnt_q + 1'b1;
			case (tx_st_q)
			`LHS_TX_IDLE: begin
				tx_o   <= 1'b1;
				busy_o <= 1'b0;
				if (send_i && master_i && enable_i) begin
					tx_id_q  <= send_id_i;
					tx_bit_q <= 5'h00;
					tx_o     <= 1'b0;
					busy_o   <= 1'b1;
					tx_st_q  <= `LHS_TX_BREAK;
				end
			end
			`LHS_TX_BREAK: begin
				if (tx_tick) begin
					if (tx_bit_q == `LHS_BREAK_BITS - 1'b1) begin
						tx_o    <= 1'b1;
						tx_st_q <= `LHS_TX_DELIM;
					end else begin
						tx_bit_q <= tx_bit_q + 1'b1;
					end
				end
			end
			// One recessive bit separates the break from the sync character.
			`LHS_TX_DELIM: begin
				if (tx_tick) begin
					tx_sh_q     <= {1'b1, `LHS_SYNC_BYTE, 1'b0};
					tx_o        <= 1'b0;
					tx_second_q <= 1'b0;
					tx_bit_q    <= 5'h00;
					tx_st_q     <= `LHS_TX_CHAR;
				end
			end
			// Each character is ten bit times: start, eight data bits LSB first, stop.
			`LHS_TX_CHAR: begin
				if (tx_tick) begin
					if (tx_bit_q == {1'b0, `LHS_CHAR_BITS} - 1'b1) begin
						tx_bit_q <= 5'h00;
						if (!tx_second_q) begin
							tx_sh_q     <= {1'b1, tx_id_q, 1'b0};
							tx_o        <= 1'b0;
							tx_second_q <= 1'b1;
						end else begin
							tx_o    <= 1'b1;
							busy_o  <= 1'b0;
							tx_st_q <= `LHS_TX_IDLE;
						end
					end else begin
						tx_bit_q <= tx_bit_q + 1'b1;
						tx_sh_q  <= {1'b1, tx_sh_q[9:1]};
						tx_o     <= tx_sh_q[1];
					end
				end
			end
			default: begin
				tx_st_q <= `LHS_TX_IDLE;
			end
			endcase
		end
	end

	// ------------------------------------------------------------------------
	// Slave header detection and bit time measurement
	// ------------------------------------------------------------------------
	reg  [2:0]    rx_st_q;
	reg  [CW-1:0] meas_q;
	reg  [CW-1:0] low_q;
	reg  [CW-1:0] rate_q;
	reg  [CW-1:0] rcnt_q;
	reg  [3:0]    edges_q;
	reg  [3:0]    rbit_q;
	reg  [7:0]    rsh_q;
	reg           rx_prev_q;
	reg           f_valid_q;
	reg  [7:0]    f_data_q;
	wire          fall;
	wire          f_ready;
	wire          o_valid;
	wire [7:0]    o_data;
	wire [CW-1:0] brk_min;
	wire [CW-1:0] id_first;
	wire [CW-1:0] id_next;

	assign fall = rx_prev_q & ~rx_i;
	// A low run shorter than 12.5 bit times of the last rate is a data bit, not a break.
	assign brk_min = rate_q * `LHS_BREAK_BITS - {1'b0, rate_q[CW-1:1]};
	// Reload values are one short because the sampling edge itself takes one clock.
	assign id_first = rate_q + {1'b0, rate_q[CW-1:1]} - 1'b1;
	assign id_next  = rate_q - 1'b1;

	// Receiver: break, sync edges, then the identifier sampled mid-bit.
	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rx_st_q   <= `LHS_RX_IDLE;
			meas_q    <= {CW{1'b0}};
			low_q     <= {CW{1'b0}};
			rate_q    <= BIT_CYC[CW-1:0];
			rcnt_q    <= {CW{1'b0}};
			edges_q   <= 4'h0;
			rbit_q    <= 4'h0;
			rsh_q     <= 8'h00;
			rx_prev_q <= 1'b1;
			f_valid_q <= 1'b0;
			f_data_q  <= 8'h00;
			synced_o  <= 1'b0;
			frame_o   <= 1'b0;
		end else begin
			rx_prev_q <= rx_i;
			frame_o   <= 1'b0;
			if (f_valid_q && f_ready) begin
				f_valid_q <= 1'b0;
			end
			if (!enable_i || master_i) begin
				// A half-received identifier must not resume after a mode change.
				rx_st_q  <= `LHS_RX_IDLE;
				synced_o <= 1'b0;
				rbit_q   <= 4'h0;
				rcnt_q   <= {CW{1'b0}};
			end else begin
				case (rx_st_q)
				`LHS_RX_IDLE: begin
					if (fall) begin
						low_q   <= {CW{1'b0}};
						rx_st_q <= `LHS_RX_BREAK;
					end
				end
				`LHS_RX_BREAK: begin
					if (!rx_i) begin
						if (low_q != {CW{1'b1}}) begin
							low_q <= low_q + 1'b1;
						end
					end else if (low_q >= brk_min) begin
						synced_o <= 1'b0;
						rx_st_q  <= `LHS_RX_WAITSYNC;
					end else begin
						rx_st_q <= `LHS_RX_IDLE;
					end
				end
				// The falling edge of the sync start bit opens the measurement.
				`LHS_RX_WAITSYNC: begin
					if (fall) begin
						meas_q  <= {CW{1'b0}};
						edges_q <= 4'h0;
						rx_st_q <= `LHS_RX_MEASURE;
					end
				end
				`LHS_RX_MEASURE: begin
					meas_q <= meas_q + 1'b1;
					if (fall) begin
						if (edges_q == 4'h3) begin
							rate_q   <= {3'b000, meas_q[CW-1:3]} + 1'b1;
							synced_o <= 1'b1;
							frame_o  <= 1'b1;
							rbit_q   <= 4'h0;
							rcnt_q   <= {CW{1'b0}};
							rx_st_q  <= `LHS_RX_ID;
						end else begin
							edges_q <= edges_q + 1'b1;
						end
					end else if (meas_q == {CW{1'b1}}) begin
						// A sync field that never ends drops back to waiting for a break.
						rx_st_q <= `LHS_RX_IDLE;
					end
				end
				// Wait for the start edge, sample 1.5 bits later and then every bit.
				`LHS_RX_ID: begin
					if (rbit_q == 4'h0 && rcnt_q == {CW{1'b0}} && !fall) begin
						rcnt_q <= {CW{1'b0}};
					end else if (rbit_q == 4'h0 && rcnt_q == {CW{1'b0}}) begin
						rcnt_q <= id_first;
						rbit_q <= 4'h1;
					end else if (rcnt_q != {CW{1'b0}}) begin
						rcnt_q <= rcnt_q - 1'b1;
					end else begin
						rsh_q  <= {rx_i, rsh_q[7:1]};
						rcnt_q <= id_next;
						rbit_q <= rbit_q + 1'b1;
						if (rbit_q == 4'h8) begin
							f_valid_q <= 1'b1;
							f_data_q  <= {rx_i, rsh_q[7:1]};
							rbit_q    <= 4'h0;
							rcnt_q    <= {CW{1'b0}};
							rx_st_q   <= `LHS_RX_IDLE;
						end
					end
				end
				default: begin
					rx_st_q <= `LHS_RX_IDLE;
				end
				endcase
			end
		end
	end

	// ------------------------------------------------------------------------
	// Identifier buffer and registered outputs
	// ------------------------------------------------------------------------
	wire out_take;

	assign out_take = ~id_valid_o | id_ready_i;

	lhs_fifo #(
		.WIDTH (8),
		.DEPTH (FIFO_DEPTH),
		.AW    (3)
	) lhs_fifo_i (
		.clk_i       (clk_i),
		.nrst_i      (nrst_i),
		.in_valid_i  (f_valid_q),
		.in_ready_o  (f_ready),
		.in_data_i   (f_data_q),
		.out_valid_o (o_valid),
		.out_ready_i (out_take),
		.out_data_o  (o_data)
	);

	// The output stage refills whenever it is empty or being drained.
	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			id_valid_o   <= 1'b0;
			id_data_o    <= 8'h00;
			bit_cycles_o <= {CW{1'b0}};
		end else begin
			bit_cycles_o <= rate_q;
			if (out_take) begin
				id_valid_o <= o_valid;
				id_data_o  <= o_data;
			end
		end
	end
endmodule
`default_nettype wire

// File: tb/lhs_core_props.sv
// Port checker for the frame header engine.
// Assumes binding into lhs_core; one clock, reset active low.
`timescale 1ns/10ps
`default_nettype none
module lhs_core_props #(
	parameter BIT_CYC = 16
) (
	// Clock, reset and controls
	input wire logic       clk_i, nrst_i, enable_i, master_i, send_i, id_ready_i,
	// Outputs watched
	input wire logic       tx_o, busy_o, synced_o, frame_o, id_valid_o,
	input wire logic [7:0] id_data_o
);
	logic [15:0] lo_q;
	logic [15:0] bz_q;
	// Run lengths of a low line and of a busy header, for the timing checks.
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			lo_q <= 16'h0000;
			bz_q <= 16'h0000;
		end else begin
			lo_q <= tx_o ? 16'h0000 : lo_q + 16'h0001;
			bz_q <= busy_o ? bz_q + 16'h0001 : 16'h0000;
		end
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	hdr_start_a: assert property (send_i && master_i && enable_i && !busy_o |=> busy_o && !tx_o)
		else $error("header did not start");
	start_cause_a: assert property ($rose(busy_o) |-> $past(send_i && master_i && enable_i))
		else $error("header started unasked");
	break_len_a: assert property ($rose(tx_o) |-> lo_q == 13 * BIT_CYC || lo_q <= 9 * BIT_CYC)
		else $error("low run length wrong");
	hdr_len_a: assert property ($fell(busy_o) |-> bz_q == 34 * BIT_CYC)
		else $error("header length wrong");
	idle_high_a: assert property (!busy_o |-> tx_o)
		else $error("line not recessive");
	frame_pulse_a: assert property (frame_o |=> !frame_o)
		else $error("frame pulse too long");
	sync_flag_a: assert property (frame_o |-> ##[0:2] synced_o)
		else $error("rate not adopted");
	master_quiet_a: assert property (master_i && $past(master_i) |-> !frame_o)
		else $error("frame seen in master mode");
	id_hold_a: assert property (id_valid_o && !id_ready_i |=> id_valid_o && $stable(id_data_o))
		else $error("identifier dropped");
endmodule
bind lhs_core lhs_core_props #(.BIT_CYC(BIT_CYC)) lhs_core_props_i (
	.clk_i, .nrst_i, .enable_i, .master_i, .send_i, .id_ready_i,
	.tx_o, .busy_o, .synced_o, .frame_o, .id_valid_o, .id_data_o
);
`default_nettype wire

// File: tb/lhs_lin_node.sv
// Model of a LIN master node driving headers onto the bus.
// Assumes each task is entered at a falling clock edge.
`timescale 1ns/10ps
`default_nettype none
module lhs_lin_node (
	// Clock
	input  wire logic clk_i,
	// Bus drive, released high by the pull-up
	output var  logic line_o
);
	initial line_o = 1'b1;
	task automatic hold(input int n, input logic v);
		line_o <= v;
		repeat (n) @(negedge clk_i);
	endtask
	task automatic send_char(input int bt, input logic [7:0] d);
		hold(bt, 1'b0);
		for (int i = 0; i < 8; i++)
			hold(bt, d[i]);
		hold(bt, 1'b1);
	endtask
	task automatic header(input int bt, input int brk, input logic [7:0] id);
		hold(brk * bt, 1'b0);
		hold(bt, 1'b1);
		send_char(bt, 8'h55);
		send_char(bt, id);
		hold(3 * bt, 1'b1);
	endtask
endmodule
`default_nettype wire

// File: tb/tb_lhs_core.sv
// Testbench for the header engine: master sending, slave detection,
// rate measurement and the identifier FIFO.
// Assumes the design under hw/ and the node model and checker under tb/.
`timescale 1ns/10ps
`default_nettype none
module tb_lhs_core;
	localparam int B = 16;
	logic        clk_i = 1'b0, nrst_i = 1'b0, enable_i = 1'b0, master_i = 1'b0;
	logic        send_i = 1'b0, id_ready_i = 1'b0;
	logic [7:0]  send_id_i = 8'h00;
	wire         node_w, tx_o, busy_o, synced_o, frame_o, id_valid_o;
	wire  [19:0] bit_cycles_o;
	wire  [7:0]  id_data_o;
	wire         rx_i = tx_o & node_w;
	int          failures = 0;
	int          n_tests = 0;
	logic [33:0] hdr_q[$];
	logic [7:0]  id_q[$];
	int          rate_q[$];
	always #5 clk_i = ~clk_i;
	lhs_core #(.BIT_CYC(B)) lhs_core_i (
		.clk_i, .nrst_i, .enable_i, .master_i, .send_i, .send_id_i, .rx_i, .tx_o,
		.busy_o, .synced_o, .bit_cycles_o, .frame_o, .id_valid_o, .id_ready_i, .id_data_o
	);
	lhs_lin_node lhs_lin_node_i (.clk_i(clk_i), .line_o(node_w));
	task automatic check(input string s, input logic [33:0] e, input logic [33:0] g);
		n_tests++;
		if (g !== e) begin
			failures++;
			$display("BAD %s exp %h got %h", s, e, g);
		end
	endtask
	task automatic print_verdict;
		if (failures == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// Drains everything outstanding with reads stalling at random.
	task automatic settle;
		int k;
		for (k = 0; k < 20000; k++) begin
			if (busy_o === 1'b0 && !hdr_q.size() && !id_q.size() && !rate_q.size())
				break;
			id_ready_i = 1'($urandom);
			@(negedge clk_i);
		end
		id_ready_i = 1'b0;
		if (k == 20000) begin
			check("settle", 34'h0, 34'h1);
			print_verdict();
		end
	endtask
	task automatic slave_hdr(input int bt, input int brk);
		logic [7:0] id;
		id = 8'($urandom);
		id_q.push_back(id);
		rate_q.push_back(bt);
		lhs_lin_node_i.header(bt, brk, id);
	endtask
	initial begin
		logic [33:0] v;
		forever begin
			@(negedge clk_i);
			if (busy_o === 1'b1) begin
				for (int k = 0; k < 34; k++) begin
					repeat (k ? B : B / 2) @(negedge clk_i);
					v[k] = tx_o;
				end
				check("tx", hdr_q.size() ? hdr_q.pop_front() : 34'hx, v);
				for (int w = 0; w < B && busy_o === 1'b1; w++)
					@(negedge clk_i);
				check("hdr end", 34'h0, 34'(busy_o));
			end
		end
	end
	always @(posedge clk_i) begin
		if (id_valid_o === 1'b1 && id_ready_i === 1'b1)
			check("id", id_q.size() ? id_q.pop_front() : 8'hx, id_data_o);
	end
	always @(posedge clk_i) begin
		int r;
		logic [19:0] g;
		if (frame_o === 1'b1) begin
			repeat (2) @(negedge clk_i);
			r = rate_q.size() ? rate_q.pop_front() : -9;
			g = bit_cycles_o;
			check("rate", 34'(r), (g === 20'(r - 1) || g === 20'(r + 1)) ? 34'(r) : 34'(g));
			check("synced", 34'h1, 34'(synced_o));
		end
	end
	initial begin
		void'($urandom(32'h430B254C));
		repeat (8) @(negedge clk_i);
		nrst_i = 1'b1;
		enable_i = 1'b1;
		send_i = 1'b1;
		slave_hdr(B, 13);
		slave_hdr(20, 13);
		slave_hdr(B, 17);
		lhs_lin_node_i.hold(5 * B, 1'b0);
		lhs_lin_node_i.hold(20 * B, 1'b1);
		send_i = 1'b0;
		settle();
		for (int k = 0; k < 8; k++)
			slave_hdr(B, 17);
		settle();
		master_i = 1'b1;
		enable_i = 1'b0;
		send_i = 1'b1;
		repeat (2) @(negedge clk_i);
		send_i = 1'b0;
		check("off", 34'h0, 34'(busy_o));
		enable_i = 1'b1;
		for (int k = 0; k < 3; k++) begin
			send_id_i = 8'($urandom);
			hdr_q.push_back({1'b1, send_id_i, 2'b01, 8'h55, 1'b0, 1'b1, 13'h0000});
			send_i = 1'b1;
			@(negedge clk_i);
			send_i = 1'b0;
			repeat (3 * B) @(negedge clk_i);
			send_i = 1'b1;
			@(negedge clk_i);
			send_i = 1'b0;
			for (int w = 0; w < 40 * B && busy_o === 1'b1; w++)
				@(negedge clk_i);
			check("busy", 34'h0, 34'(busy_o));
		end
		settle();
		print_verdict();
	end
endmodule
`default_nettype wire
